/* File: dv/dmt_cpu_model.sv */
// CPU-side model of the byte-wide peripheral bus master
`timescale 1ns/100ps
module dmt_cpu_model (
    // Clock
    input wire logic mclk,
    // Peripheral bus
    output logic [15:0] busAddr,
    output logic busWr,
    output logic busRd,
    output logic [7:0] busWrData,
    input wire logic [7:0] busRdData_r
);
    initial begin
        busAddr = 16'h0000;
        busWr = 1'b0;
        busRd = 1'b0;
        busWrData = 8'h00;
    end
    // One byte write, held across exactly one sampling edge
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge mclk);
        busAddr <= a;
        busWrData <= d;
        busWr <= 1'b1;
        @(posedge mclk);
        busWr <= 1'b0;
        // Released data must not keep showing the last value
        busWrData <= ~d;
        #1;
    endtask
    // One byte read; data is registered at the sampling edge
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge mclk);
        busAddr <= a;
        busRd <= 1'b1;
        @(posedge mclk);
        busRd <= 1'b0;
        #1;
        d = busRdData_r;
    endtask
endmodule

/* File: dv/dmt_timer_tb.sv */
// Self-checking bench for the dual mode compare timer
`timescale 1ns/100ps
`define CHK(g, e) begin nCompared++; if ((g) !== (e)) begin miscompares++; $display("Error t=%0t got=%h exp=%h", $time, (g), (e)); end end
module dmt_timer_tb;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic subClkDiv4 = 1'b0;
    logic irqEnUpper = 1'b0;
    logic irqEnLower = 1'b0;
    logic irqReqClrUpper = 1'b0;
    logic irqReqClrLower = 1'b0;
    logic [15:0] busAddr;
    logic busWr, busRd;
    logic [7:0] busWrData, busRdData_r, rdData;
    logic irqReqUpper_r, irqReqLower_r, irqUpper_r, irqLower_r;
    logic togglePinUpper_r, togglePinLower_r;
    logic [2:0] subCnt = 3'h0;
    wire [2:0] evt = {irqReqUpper_r, togglePinUpper_r, togglePinLower_r};
    int miscompares = 0;
    int nCompared = 0;
    int cycles = 0;
    always #12.5 mclk = ~mclk;
    dmt_timer dmt_timer_inst (.mclk(mclk), .reset(reset), .busAddr(busAddr), .busWr(busWr),
        .busRd(busRd), .busWrData(busWrData), .busRdData_r(busRdData_r),
        .subClkDiv4(subClkDiv4), .irqEnUpper(irqEnUpper), .irqEnLower(irqEnLower),
        .irqReqClrUpper(irqReqClrUpper), .irqReqClrLower(irqReqClrLower),
        .irqReqUpper_r(irqReqUpper_r), .irqReqLower_r(irqReqLower_r),
        .irqUpper_r(irqUpper_r), .irqLower_r(irqLower_r),
        .togglePinUpper_r(togglePinUpper_r), .togglePinLower_r(togglePinLower_r));
    dmt_cpu_model dmt_cpu_model_inst (.mclk(mclk), .busAddr(busAddr), .busWr(busWr),
        .busRd(busRd), .busWrData(busWrData), .busRdData_r(busRdData_r));
    // ==========================================================
    // Subclock enable and hang guard
    always @(posedge mclk) begin
        subCnt <= subCnt + 3'h1;
        subClkDiv4 <= (subCnt == 3'h7);
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            close_out();
        end
    end
    task automatic close_out();
        $display("Compared %0d, mismatches %0d", nCompared, miscompares);
        if (miscompares == 0 && nCompared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        dmt_cpu_model_inst.wr(a, d);
    endtask
    task automatic rdChk(input logic [15:0] a, input logic [7:0] e);
        dmt_cpu_model_inst.rd(a, rdData);
        `CHK(rdData, e)
    endtask
    // Bounded wait for one event line to change
    task automatic waitChg(input int i);
        logic s;
        int k;
        s = evt[i];
        k = 0;
        while (evt[i] === s && k < 400) begin
            @(posedge mclk);
            #1;
            k++;
        end
        `CHK(k < 400, 1'b1)
    endtask
    // ==========================================================
    // Main sequence
    initial begin
        repeat (10) @(posedge mclk);
        reset <= 1'b0;
        rdChk(dmt_pkg::ADDR_CNT_HI, 8'h00);
        rdChk(dmt_pkg::ADDR_CNT_LO, 8'h00);
        rdChk(dmt_pkg::ADDR_CMP_HI, 8'hFF);
        rdChk(dmt_pkg::ADDR_CMP_LO, 8'hFF);
        rdChk(dmt_pkg::ADDR_CTRL, dmt_pkg::RD_FILL);
        rdChk(dmt_pkg::ADDR_CTRL_STAT, 8'h00);
        rdChk(dmt_pkg::ADDR_CLK_STOP, 8'hFF);
        rdChk(16'hFFBC, dmt_pkg::RD_FILL);
        wr(dmt_pkg::ADDR_CTRL, 8'h88);
        `CHK({togglePinUpper_r, togglePinLower_r}, 2'b11)
        wr(dmt_pkg::ADDR_CTRL, 8'h00);
        `CHK({togglePinUpper_r, togglePinLower_r}, 2'b00)
        wr(dmt_pkg::ADDR_CNT_HI, 8'hAA);
        wr(dmt_pkg::ADDR_CNT_LO, 8'h55);
        rdChk(dmt_pkg::ADDR_CNT_HI, 8'hAA);
        rdChk(dmt_pkg::ADDR_CNT_LO, 8'h55);
        wr(dmt_pkg::ADDR_CMP_HI, 8'h00);
        wr(dmt_pkg::ADDR_CMP_LO, 8'h10);
        rdChk(dmt_pkg::ADDR_CMP_HI, 8'h00);
        rdChk(dmt_pkg::ADDR_CMP_LO, 8'h10);
        wr(dmt_pkg::ADDR_CTRL_STAT, 8'hFF);
        rdChk(dmt_pkg::ADDR_CTRL_STAT, 8'h33);
        // 16-bit wrap from FFFC on the /4 tick
        irqEnUpper <= 1'b1;
        wr(dmt_pkg::ADDR_CTRL_STAT, 8'h20);
        wr(dmt_pkg::ADDR_CNT_HI, 8'hFF);
        wr(dmt_pkg::ADDR_CNT_LO, 8'hFC);
        wr(dmt_pkg::ADDR_CTRL, 8'h06);
        waitChg(2);
        @(posedge mclk);
        #1;
        `CHK(irqUpper_r, 1'b1)
        wr(dmt_pkg::ADDR_CTRL, 8'h00);
        rdChk(dmt_pkg::ADDR_CTRL_STAT, 8'hA0);
        @(posedge mclk);
        irqReqClrUpper <= 1'b1;
        @(posedge mclk);
        irqReqClrUpper <= 1'b0;
        #1;
        `CHK(irqReqUpper_r, 1'b0)
        // 16-bit match at 0010 with clear on match
        wr(dmt_pkg::ADDR_CTRL_STAT, 8'h10);
        wr(dmt_pkg::ADDR_CNT_HI, 8'h00);
        wr(dmt_pkg::ADDR_CNT_LO, 8'h00);
        wr(dmt_pkg::ADDR_CTRL, 8'h06);
        waitChg(1);
        `CHK(togglePinUpper_r, 1'b1)
        rdChk(dmt_pkg::ADDR_CNT_HI, 8'h00);
        rdChk(dmt_pkg::ADDR_CNT_LO, 8'h00);
        `CHK(irqReqUpper_r, 1'b1)
        wr(dmt_pkg::ADDR_CTRL, 8'h00);
        rdChk(dmt_pkg::ADDR_CTRL_STAT, 8'h50);
        // 8-bit mode: upper on subclock, lower on /4 with match at 03
        irqEnLower <= 1'b1;
        wr(dmt_pkg::ADDR_CTRL, 8'h70);
        wr(dmt_pkg::ADDR_CMP_HI, 8'hFF);
        wr(dmt_pkg::ADDR_CMP_LO, 8'h03);
        wr(dmt_pkg::ADDR_CNT_LO, 8'h00);
        // Upper may have matched the old 00 compare: arm its flags, then clear
        dmt_cpu_model_inst.rd(dmt_pkg::ADDR_CTRL_STAT, rdData);
        wr(dmt_pkg::ADDR_CTRL_STAT, 8'h01);
        wr(dmt_pkg::ADDR_CTRL, 8'h76);
        waitChg(0);
        rdChk(dmt_pkg::ADDR_CNT_LO, 8'h00);
        `CHK({irqReqLower_r, irqLower_r}, 2'b11)
        irqEnLower <= 1'b0;
        repeat (2) @(posedge mclk);
        #1;
        `CHK(irqLower_r, 1'b0)
        wr(dmt_pkg::ADDR_CTRL, 8'h70);
        rdChk(dmt_pkg::ADDR_CTRL_STAT, 8'h05);
        wr(dmt_pkg::ADDR_CTRL_STAT, 8'h01);
        rdChk(dmt_pkg::ADDR_CTRL_STAT, 8'h01);
        @(posedge mclk);
        irqReqClrLower <= 1'b1;
        @(posedge mclk);
        irqReqClrLower <= 1'b0;
        #1;
        `CHK(irqReqLower_r, 1'b0)
        // 8-bit lower wrap, then a match without clear
        wr(dmt_pkg::ADDR_CTRL_STAT, 8'h02);
        wr(dmt_pkg::ADDR_CNT_LO, 8'hFC);
        wr(dmt_pkg::ADDR_CTRL, 8'h76);
        waitChg(0);
        wr(dmt_pkg::ADDR_CTRL, 8'h70);
        rdChk(dmt_pkg::ADDR_CNT_LO, 8'h04);
        `CHK(irqReqLower_r, 1'b1)
        rdChk(dmt_pkg::ADDR_CTRL_STAT, 8'h0E);
        // Module standby holds the count
        wr(dmt_pkg::ADDR_CLK_STOP, 8'hFB);
        rdChk(dmt_pkg::ADDR_CLK_STOP, 8'hFB);
        wr(dmt_pkg::ADDR_CTRL, 8'h76);
        repeat (40) @(posedge mclk);
        rdChk(dmt_pkg::ADDR_CNT_LO, 8'h04);
        wr(dmt_pkg::ADDR_CLK_STOP, 8'hFF);
        close_out();
    end
endmodule

/* File: include/dmt_pkg.sv */
// Shared constants for the dual mode compare timer
package dmt_pkg;
    // ==========================================================
    // Register addresses on the 8-bit peripheral bus
    localparam logic [15:0] ADDR_CTRL = 16'hFFB6;
    localparam logic [15:0] ADDR_CTRL_STAT = 16'hFFB7;
    localparam logic [15:0] ADDR_CNT_HI = 16'hFFB8;
    localparam logic [15:0] ADDR_CNT_LO = 16'hFFB9;
    localparam logic [15:0] ADDR_CMP_HI = 16'hFFBA;
    localparam logic [15:0] ADDR_CMP_LO = 16'hFFBB;
    localparam logic [15:0] ADDR_CLK_STOP = 16'hFFFA;
    // ==========================================================
    // Reset values and the byte maximum
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic [7:0] RST_CNT = 8'h00;
    localparam logic [7:0] RST_CMP = 8'hFF;
    localparam logic [7:0] RST_CLK_STOP = 8'hFF;
    localparam logic [7:0] BYTE_MAX = 8'hFF;
    // Writable bits of the clock stop register; the rest read as one
    localparam logic [7:0] CLK_STOP_RW_MASK = 8'h35;
    // Value returned for the write-only control register and holes
    localparam logic [7:0] RD_FILL = 8'hFF;
    // ==========================================================
    // Field positions
    localparam int CTRL_OUT_LVL_UP = 7;
    localparam int CTRL_MODE_BIT = 6;
    localparam int CTRL_SEL_UP_LSB = 4;
    localparam int CTRL_OUT_LVL_LO = 3;
    localparam int CTRL_SEL_LO_LSB = 0;
    localparam int ST_WRAP_UP = 7;
    localparam int ST_MATCH_UP = 6;
    localparam int ST_WRAP_EN_UP = 5;
    localparam int ST_CLR_UP = 4;
    localparam int ST_WRAP_LO = 3;
    localparam int ST_MATCH_LO = 2;
    localparam int ST_WRAP_EN_LO = 1;
    localparam int ST_CLR_LO = 0;
    localparam int CLK_STOP_RUN_BIT = 2;
    // ==========================================================
    // Clock-select codes
    localparam logic [2:0] SEL_DIV32 = 3'h4;
    localparam logic [2:0] SEL_DIV16 = 3'h5;
    localparam logic [2:0] SEL_DIV4 = 3'h6;
    localparam logic [2:0] SEL_SUB4 = 3'h7;
    // ==========================================================
    // Prescaler: 5-bit phase counter, tap masks for each division
    localparam int PRE_WIDTH = 5;
    localparam logic [4:0] PRE_MASK_DIV4 = 5'h03;
    localparam logic [4:0] PRE_MASK_DIV16 = 5'h0F;
    localparam logic [4:0] PRE_MASK_DIV32 = 5'h1F;
endpackage

/* File: include/dmt_tick_if.sv */
// Count-enable ticks from the prescaler to the timer core
`timescale 1ns/100ps
interface dmt_tick_if;
    logic tickDiv4;
    logic tickDiv16;
    logic tickDiv32;
    logic tickSub4;
    modport src (output tickDiv4, output tickDiv16, output tickDiv32, output tickSub4);
    modport dst (input tickDiv4, input tickDiv16, input tickDiv32, input tickSub4);
endinterface

/* File: logic/dmt_prescale.sv */
// Prescaler producing one-cycle count enables from the system clock
`timescale 1ns/100ps
module dmt_prescale (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // Subclock divided by four, one-cycle pulse synchronous to mclk
    input wire logic subClkDiv4,
    // Tick outputs
    dmt_tick_if.src tk
);
    logic [dmt_pkg::PRE_WIDTH-1:0] phase_r;

    // ==========================================================
    // Free-running phase; taps fire once per division period
    always_ff @(posedge mclk) begin
        if (reset) begin
            phase_r <= '0;
            tk.tickDiv4 <= 1'b0;
            tk.tickDiv16 <= 1'b0;
            tk.tickDiv32 <= 1'b0;
            tk.tickSub4 <= 1'b0;
        end else begin
            phase_r <= phase_r + 5'h01;
            tk.tickDiv4 <= (phase_r & dmt_pkg::PRE_MASK_DIV4) == dmt_pkg::PRE_MASK_DIV4;
            tk.tickDiv16 <= (phase_r & dmt_pkg::PRE_MASK_DIV16) == dmt_pkg::PRE_MASK_DIV16;
            tk.tickDiv32 <= phase_r == dmt_pkg::PRE_MASK_DIV32;
            tk.tickSub4 <= subClkDiv4;
        end
    end
endmodule

/* File: logic/dmt_timer.sv */
// Dual mode compare timer: one 16-bit or two 8-bit counters with compare
`timescale 1ns/100ps
module dmt_timer (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // Peripheral bus
    input wire logic [15:0] busAddr,
    input wire logic busWr,
    input wire logic busRd,
    input wire logic [7:0] busWrData,
    output logic [7:0] busRdData_r,
    // Subclock divided by four, one-cycle pulse
    input wire logic subClkDiv4,
    // Interrupt enables and request clears from the interrupt controller
    input wire logic irqEnUpper,
    input wire logic irqEnLower,
    input wire logic irqReqClrUpper,
    input wire logic irqReqClrLower,
    // Interrupt outputs
    output logic irqReqUpper_r,
    output logic irqReqLower_r,
    output logic irqUpper_r,
    output logic irqLower_r,
    // Toggle pins
    output logic togglePinUpper_r,
    output logic togglePinLower_r
);
    dmt_tick_if tk ();

    dmt_prescale u_pre (
        .mclk(mclk),
        .reset(reset),
        .subClkDiv4(subClkDiv4),
        .tk(tk.src)
    );

    logic [7:0] ctrlReg_r;
    logic [7:0] cntUp_r;
    logic [7:0] cntLo_r;
    logic [7:0] cmpUp_r;
    logic [7:0] cmpLo_r;
    logic [7:0] temp_r;
    logic [7:0] clkStop_r;
    logic wrapUp_r;
    logic matchUp_r;
    logic wrapEnUp_r;
    logic clrUp_r;
    logic wrapLo_r;
    logic matchLo_r;
    logic wrapEnLo_r;
    logic clrLo_r;
    logic [3:0] armed_r;

    // ==========================================================
    // Clock-select decode, shared by both halves
    function automatic logic selTick(input logic [2:0] sel, input logic t4,
                                     input logic t16, input logic t32, input logic ts);
        case (sel)
            dmt_pkg::SEL_DIV32: selTick = t32;
            dmt_pkg::SEL_DIV16: selTick = t16;
            dmt_pkg::SEL_DIV4: selTick = t4;
            dmt_pkg::SEL_SUB4: selTick = ts;
            default: selTick = 1'b0;
        endcase
    endfunction

    // ==========================================================
    // Bus decode
    wire wrCtrl = busWr && busAddr == dmt_pkg::ADDR_CTRL;
    wire wrStat = busWr && busAddr == dmt_pkg::ADDR_CTRL_STAT;
    wire wrCntUp = busWr && busAddr == dmt_pkg::ADDR_CNT_HI;
    wire wrCntLo = busWr && busAddr == dmt_pkg::ADDR_CNT_LO;
    wire wrCmpUp = busWr && busAddr == dmt_pkg::ADDR_CMP_HI;
    wire wrCmpLo = busWr && busAddr == dmt_pkg::ADDR_CMP_LO;
    wire wrStop = busWr && busAddr == dmt_pkg::ADDR_CLK_STOP;
    wire rdStat = busRd && busAddr == dmt_pkg::ADDR_CTRL_STAT;
    wire rdCntUp = busRd && busAddr == dmt_pkg::ADDR_CNT_HI;
    wire rdCmpUp = busRd && busAddr == dmt_pkg::ADDR_CMP_HI;

    // ==========================================================
    // Mode and count enables
    wire mode8 = ctrlReg_r[dmt_pkg::CTRL_MODE_BIT];
    wire running = clkStop_r[dmt_pkg::CLK_STOP_RUN_BIT];
    wire [2:0] selUp = ctrlReg_r[dmt_pkg::CTRL_SEL_UP_LSB +: 3];
    wire [2:0] selLo = ctrlReg_r[dmt_pkg::CTRL_SEL_LO_LSB +: 3];
    wire tickLo = running && selTick(selLo, tk.tickDiv4, tk.tickDiv16,
                                     tk.tickDiv32, tk.tickSub4);
    wire loAtMax = cntLo_r == dmt_pkg::BYTE_MAX;
    wire upAtMax = cntUp_r == dmt_pkg::BYTE_MAX;
    // Chained mode carries the low byte's wrap into the upper byte
    wire tickUp = mode8 ? (running && selTick(selUp, tk.tickDiv4, tk.tickDiv16,
                                              tk.tickDiv32, tk.tickSub4))
                        : (tickLo && loAtMax);

    // ==========================================================
    // Compare matches, taken at the count event while equal
    wire eqUp = cntUp_r == cmpUp_r;
    wire eqLo = cntLo_r == cmpLo_r;
    wire match16 = !mode8 && tickLo && eqUp && eqLo;
    wire matchUp8 = mode8 && tickUp && eqUp;
    wire matchLo8 = mode8 && tickLo && eqLo;
    wire clearFull = match16 && clrUp_r;
    wire clearUp = clearFull || (matchUp8 && clrUp_r);
    wire clearLo = clearFull || (matchLo8 && clrLo_r);
    wire wrap16 = !mode8 && tickLo && loAtMax && upAtMax && !clearFull;
    wire wrapUp8 = mode8 && tickUp && upAtMax && !clearUp;
    wire wrapLo8 = mode8 && tickLo && loAtMax && !clearLo;
    wire setWrapUp = wrap16 || wrapUp8;
    wire setMatchUp = match16 || matchUp8;

    // ==========================================================
    // Counter next values; a CPU write beats a count event
    wire commit16 = !mode8 && wrCntLo;
    wire [7:0] cntUp_nxt = (mode8 && wrCntUp) ? busWrData :
                           commit16 ? temp_r :
                           clearUp ? dmt_pkg::RST_CNT :
                           tickUp ? 8'(cntUp_r + 8'h01) : cntUp_r;
    wire [7:0] cntLo_nxt = wrCntLo ? busWrData :
                           clearLo ? dmt_pkg::RST_CNT :
                           tickLo ? 8'(cntLo_r + 8'h01) : cntLo_r;

    // ==========================================================
    // Status flag clearing: a zero written to an armed flag clears it
    wire [3:0] flagsNow = {wrapUp_r, matchUp_r, wrapLo_r, matchLo_r};
    wire [3:0] wrFlagBits = {busWrData[dmt_pkg::ST_WRAP_UP], busWrData[dmt_pkg::ST_MATCH_UP],
                             busWrData[dmt_pkg::ST_WRAP_LO], busWrData[dmt_pkg::ST_MATCH_LO]};
    wire [3:0] clrFlag = {4{wrStat}} & armed_r & ~wrFlagBits;
    wire [7:0] statRd = {wrapUp_r, matchUp_r, wrapEnUp_r, clrUp_r,
                         wrapLo_r, matchLo_r, wrapEnLo_r, clrLo_r};

    // ==========================================================
    // Read mux; 16-bit lower reads come from the latch
    wire [7:0] rdMux =
        (busAddr == dmt_pkg::ADDR_CTRL_STAT) ? statRd :
        (busAddr == dmt_pkg::ADDR_CNT_HI) ? cntUp_r :
        (busAddr == dmt_pkg::ADDR_CNT_LO) ? (mode8 ? cntLo_r : temp_r) :
        (busAddr == dmt_pkg::ADDR_CMP_HI) ? cmpUp_r :
        (busAddr == dmt_pkg::ADDR_CMP_LO) ? (mode8 ? cmpLo_r : temp_r) :
        (busAddr == dmt_pkg::ADDR_CLK_STOP) ? (clkStop_r | ~dmt_pkg::CLK_STOP_RW_MASK) :
        dmt_pkg::RD_FILL;

    // Upper write parks data; upper read parks the lower byte
    wire [7:0] temp_nxt = (!mode8 && (wrCntUp || wrCmpUp)) ? busWrData :
                          (!mode8 && rdCntUp) ? cntLo_r :
                          (!mode8 && rdCmpUp) ? cmpLo_r : temp_r;

    // Toggle pins: a control write sets the level, else matches invert
    wire togUp_nxt = wrCtrl ? busWrData[dmt_pkg::CTRL_OUT_LVL_UP] :
                     setMatchUp ? !togglePinUpper_r : togglePinUpper_r;
    wire togLo_nxt = wrCtrl ? busWrData[dmt_pkg::CTRL_OUT_LVL_LO] :
                     matchLo8 ? !togglePinLower_r : togglePinLower_r;

    // Requests: hardware set wins over a clear in the same cycle
    wire reqUp_nxt = setMatchUp || (setWrapUp && wrapEnUp_r) ||
                     (irqReqUpper_r && !irqReqClrUpper);
    wire reqLo_nxt = matchLo8 || (wrapLo8 && wrapEnLo_r) ||
                     (irqReqLower_r && !irqReqClrLower);

    // ==========================================================
    // Counters, compares, latch and bus read data
    always_ff @(posedge mclk) begin
        if (reset) begin
            cntUp_r <= dmt_pkg::RST_CNT;
            cntLo_r <= dmt_pkg::RST_CNT;
            cmpUp_r <= dmt_pkg::RST_CMP;
            cmpLo_r <= dmt_pkg::RST_CMP;
            temp_r <= dmt_pkg::RST_CNT;
            busRdData_r <= 8'h00;
        end else begin
            cntUp_r <= cntUp_nxt;
            cntLo_r <= cntLo_nxt;
            if (mode8 && wrCmpUp) begin
                cmpUp_r <= busWrData;
            end else if (!mode8 && wrCmpLo) begin
                cmpUp_r <= temp_r;
            end
            if (wrCmpLo) begin
                cmpLo_r <= busWrData;
            end
            temp_r <= temp_nxt;
            busRdData_r <= busRd ? rdMux : busRdData_r;
        end
    end

    // ==========================================================
    // Control, standby, status and output pins
    always_ff @(posedge mclk) begin
        if (reset) begin
            ctrlReg_r <= dmt_pkg::RST_CTRL;
            clkStop_r <= dmt_pkg::RST_CLK_STOP;
            {wrapUp_r, matchUp_r, wrapEnUp_r, clrUp_r} <= 4'h0;
            {wrapLo_r, matchLo_r, wrapEnLo_r, clrLo_r} <= 4'h0;
            armed_r <= 4'h0;
            togglePinUpper_r <= 1'b0;
            togglePinLower_r <= 1'b0;
            irqReqUpper_r <= 1'b0;
            irqReqLower_r <= 1'b0;
            irqUpper_r <= 1'b0;
            irqLower_r <= 1'b0;
        end else begin
            if (wrCtrl) begin
                ctrlReg_r <= busWrData;
            end
            if (wrStop) begin
                clkStop_r <= busWrData & dmt_pkg::CLK_STOP_RW_MASK;
            end
            if (wrStat) begin
                wrapEnUp_r <= busWrData[dmt_pkg::ST_WRAP_EN_UP];
                clrUp_r <= busWrData[dmt_pkg::ST_CLR_UP];
                wrapEnLo_r <= busWrData[dmt_pkg::ST_WRAP_EN_LO];
                clrLo_r <= busWrData[dmt_pkg::ST_CLR_LO];
            end
            // Set wins over clear; a one written has no effect
            wrapUp_r <= setWrapUp || (wrapUp_r && !clrFlag[3]);
            matchUp_r <= setMatchUp || (matchUp_r && !clrFlag[2]);
            wrapLo_r <= wrapLo8 || (wrapLo_r && !clrFlag[1]);
            matchLo_r <= matchLo8 || (matchLo_r && !clrFlag[0]);
            // Arming survives until a status write consumes it
            armed_r <= rdStat ? (armed_r | flagsNow) : (wrStat ? 4'h0 : armed_r);
            togglePinUpper_r <= togUp_nxt;
            togglePinLower_r <= togLo_nxt;
            irqReqUpper_r <= reqUp_nxt;
            irqReqLower_r <= reqLo_nxt;
            irqUpper_r <= irqReqUpper_r && irqEnUpper;
            irqLower_r <= irqReqLower_r && irqEnLower;
        end
    end

    // ==========================================================
    // Checks
    a_reset_counts: assert property (@(posedge mclk) reset |=>
        cntUp_r == 8'h00 && cntLo_r == 8'h00)
        else $error("counter not zero after reset");
    a_reset_compare: assert property (@(posedge mclk) reset |=>
        cmpUp_r == 8'hFF && cmpLo_r == 8'hFF)
        else $error("compare not all ones after reset");
    a_wrap_full: assert property (@(posedge mclk) disable iff (reset)
        (!mode8 && tickLo && cntUp_r == 8'hFF && cntLo_r == 8'hFF && !clrUp_r && !busWr)
        |=> wrapUp_r && cntUp_r == 8'h00 && cntLo_r == 8'h00
            && (irqReqUpper_r || !$past(wrapEnUp_r)))
        else $error("16-bit wrap not flagged");
    a_wrap_lower: assert property (@(posedge mclk) disable iff (reset)
        (wrapLo8 && wrapEnLo_r) |=> wrapLo_r && irqReqLower_r)
        else $error("lower wrap not flagged or requested");
    a_clear_full: assert property (@(posedge mclk) disable iff (reset)
        (match16 && clrUp_r && !busWr) |=> cntUp_r == 8'h00 && cntLo_r == 8'h00)
        else $error("full counter not cleared on match");
    a_clear_lower: assert property (@(posedge mclk) disable iff (reset)
        (matchLo8 && !clrLo_r && !wrCntLo) |=> cntLo_r == $past(cntLo_r) + 8'h01)
        else $error("lower counter cleared without clear enable");
    a_match_full: assert property (@(posedge mclk) disable iff (reset)
        match16 |=> matchUp_r && irqReqUpper_r ##1 irqUpper_r == $past(irqEnUpper))
        else $error("full match not flagged and requested");
    a_irq_gate: assert property (@(posedge mclk) disable iff (reset)
        irqLower_r |-> $past(irqReqLower_r) && $past(irqEnLower))
        else $error("lower interrupt without request and enable");
    a_toggle_up: assert property (@(posedge mclk) disable iff (reset)
        (setMatchUp && !wrCtrl) |=> togglePinUpper_r != $past(togglePinUpper_r))
        else $error("upper toggle pin did not invert on match");
    a_out_level: assert property (@(posedge mclk) disable iff (reset)
        wrCtrl |=> togglePinUpper_r == $past(busWrData[7])
                   && togglePinLower_r == $past(busWrData[3]))
        else $error("toggle pins not preset by control write");
    a_standby_halt: assert property (@(posedge mclk) disable iff (reset)
        (!running && !busWr) [*2] |-> $stable(cntUp_r) && $stable(cntLo_r))
        else $error("counter moved in module standby");
    a_write_wins: assert property (@(posedge mclk) disable iff (reset)
        (wrCntLo && tickLo) |=> cntLo_r == $past(busWrData))
        else $error("count event overrode CPU write");

    // ==========================================================
    // Mode, latch and flag checks
    a_chain_carry: assert property (@(posedge mclk) disable iff (reset)
        (!mode8 && tickLo && loAtMax && !clearFull && !busWr) |=> cntUp_r == $past(cntUp_r) + 8'h01)
        else $error("lower wrap did not carry into upper byte");
    a_lower_stop: assert property (@(posedge mclk) disable iff (reset)
        (!mode8 && selLo == 3'h0 && !busWr) |=> $stable(cntUp_r) && $stable(cntLo_r))
        else $error("stopped 16-bit counter moved");
    a_upper_sel: assert property (@(posedge mclk) disable iff (reset)
        (mode8 && selUp == dmt_pkg::SEL_SUB4 && !tk.tickSub4 && !busWr) |=> $stable(cntUp_r))
        else $error("upper counter moved without its tick");
    a_lower_sel: assert property (@(posedge mclk) disable iff (reset)
        (mode8 && selLo == dmt_pkg::SEL_DIV4 && !tk.tickDiv4 && !busWr) |=> $stable(cntLo_r))
        else $error("lower counter moved without its tick");
    a_match_lower: assert property (@(posedge mclk) disable iff (reset)
        matchLo8 |=> matchLo_r && irqReqLower_r)
        else $error("lower match not flagged and requested");
    a_clear_lower_hit: assert property (@(posedge mclk) disable iff (reset)
        (matchLo8 && clrLo_r && !wrCntLo) |=> cntLo_r == 8'h00)
        else $error("lower counter not cleared on match");
    a_toggle_low: assert property (@(posedge mclk) disable iff (reset)
        (matchLo8 && !wrCtrl) |=> togglePinLower_r != $past(togglePinLower_r))
        else $error("lower toggle pin did not invert on match");
    a_low_pin_quiet: assert property (@(posedge mclk) disable iff (reset)
        (!mode8 && !wrCtrl) |=> $stable(togglePinLower_r))
        else $error("lower toggle pin moved in 16-bit mode");
    a_latch_write: assert property (@(posedge mclk) disable iff (reset)
        (!mode8 && (wrCntUp || wrCmpUp)) |=> temp_r == $past(busWrData))
        else $error("upper write not parked in latch");
    a_latch_commit: assert property (@(posedge mclk) disable iff (reset)
        (!mode8 && wrCntLo) |=> cntUp_r == $past(temp_r) && cntLo_r == $past(busWrData))
        else $error("lower write did not commit both bytes");
    a_flag_hold_up: assert property (@(posedge mclk) disable iff (reset)
        (matchUp_r && !(wrStat && armed_r[2])) |=> matchUp_r)
        else $error("upper match flag lost without armed clear");
    a_flag_hold_low: assert property (@(posedge mclk) disable iff (reset)
        (matchLo_r && !(wrStat && armed_r[0])) |=> matchLo_r)
        else $error("lower match flag lost without armed clear");
    a_stat_config: assert property (@(posedge mclk) disable iff (reset)
        wrStat |=> wrapEnUp_r == $past(busWrData[dmt_pkg::ST_WRAP_EN_UP])
                   && clrUp_r == $past(busWrData[dmt_pkg::ST_CLR_UP])
                   && wrapEnLo_r == $past(busWrData[dmt_pkg::ST_WRAP_EN_LO])
                   && clrLo_r == $past(busWrData[dmt_pkg::ST_CLR_LO]))
        else $error("status control bits not written");
    a_ctrl_write: assert property (@(posedge mclk) disable iff (reset)
        wrCtrl |=> ctrlReg_r == $past(busWrData))
        else $error("control register not written");
    a_cmp_write: assert property (@(posedge mclk) disable iff (reset)
        wrCmpLo |=> cmpLo_r == $past(busWrData))
        else $error("lower compare byte not written");
    a_irq_upper: assert property (@(posedge mclk) disable iff (reset)
        irqUpper_r |-> $past(irqReqUpper_r) && $past(irqEnUpper))
        else $error("upper interrupt without request and enable");
endmodule
